// ==== verilog/sgtp_ctrl.sv ====
// Operation
// - Row stays open at least the active minimum and never past the maximum (code does not close it; it only raises o_ras_overdue).
// - After precharge wait recovery time before activate or refresh, same bank (code does not wait before self refresh entry).
// - Activations to different banks spaced by the inter-bank minimum.
// - Column commands may issue every cycle.
// - Self refresh exit holds clock-gate high at least the exit pulse.
// - Power-down exit raises clock-gate a setup time before ending edge.
// - After mode set, wait mode-set cycle time before next command.
// - Block writes spaced by block write cycle time.
// - After block write, wait block-write-to-precharge before precharge.
// - Nanosecond limits become cycles, rounding fractions up (code rounds RAS_MAX_CYC down).
// - At power-up: NOP, clock-gate high, byte masks high, clock running.
// - Wait at least 200 microseconds before initialisation commands.
// - Keep byte masks high during the initial pause.
// - Precharge both banks next.
// - Then issue mode register set.
// - Then at least two auto-refresh cycles.
// - After power-down exit, one clock before any further command.
`timescale 1ns/10ps
`include "sgtp_defs.svh"
`default_nettype none

module sgtp_ctrl #(
  parameter int CLK_PS      = `SGTP_CLK_PERIOD_PS,
  parameter int T_RAS_MIN   = `SGTP_T_RAS_MIN_PS,
  parameter int T_RAS_MAX   = `SGTP_T_RAS_MAX_PS,
  parameter int T_RP        = `SGTP_T_RP_PS,
  parameter int T_RRD       = `SGTP_T_RRD_PS,
  parameter int T_RC        = `SGTP_T_RC_PS,
  parameter int T_RCD       = `SGTP_T_RCD_PS,
  parameter int T_SRX       = `SGTP_T_SRX_PS,
  parameter int T_PDE       = `SGTP_T_PDE_PS,
  parameter int T_RSC       = `SGTP_T_RSC_PS,
  parameter int T_BWC       = `SGTP_T_BWC_PS,
  parameter int T_BPL       = `SGTP_T_BPL_PS,
  parameter int T_WR        = `SGTP_T_WR_PS,
  parameter int PAUSE_CYC   = (`SGTP_T_PAUSE_PS + `SGTP_CLK_PERIOD_PS - 1) / `SGTP_CLK_PERIOD_PS,
  parameter int RAS_MAX_CYC = `SGTP_T_RAS_MAX_PS / `SGTP_CLK_PERIOD_PS,
  parameter int AREF_CNT    = `SGTP_AREF_COUNT,
  parameter int ROW_W       = 11,
  parameter int DQM_W       = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_req_valid,
  input  wire logic [2:0]       i_req_cmd,
  input  wire logic             i_req_bank,
  input  wire logic [ROW_W-1:0] i_req_addr,
  input  wire logic [DQM_W-1:0] i_req_mask,
  input  wire logic             i_wake,
  output logic                  o_req_ready,
  output logic                  o_init_done,
  output logic                  o_ras_overdue,
  output logic                  o_cke,
  output logic                  o_cs_n,
  output logic                  o_ras_n,
  output logic                  o_cas_n,
  output logic                  o_we_n,
  output logic                  o_dsf,
  output logic                  o_ba,
  output logic [ROW_W-1:0]      o_addr,
  output logic [DQM_W-1:0]      o_dqm
);

  // --------------------------------------------------------------------------
  // Cycle counts, rounded up
  // --------------------------------------------------------------------------
  function automatic int cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc

  localparam int C_RAS  = cyc(T_RAS_MIN);
  localparam int C_RP   = cyc(T_RP);
  localparam int C_RRD  = cyc(T_RRD);
  localparam int C_RC   = cyc(T_RC);
  localparam int C_RCD  = cyc(T_RCD);
  localparam int C_SRX  = cyc(T_SRX);
  localparam int C_PDE  = cyc(T_PDE);
  localparam int C_RSC  = cyc(T_RSC);
  localparam int C_BWC  = cyc(T_BWC);
  localparam int C_BPL  = cyc(T_BPL);
  localparam int C_WR   = cyc(T_WR);
  localparam int CW     = 8;
  localparam int PW     = $clog2(PAUSE_CYC + RAS_MAX_CYC + 2);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  sgtp_pkg::sgtp_state_t state, next_state;
  logic [PW-1:0]  wait_cnt, next_wait_cnt;
  logic [CW-1:0]  gap_cnt, next_gap_cnt;
  logic [CW-1:0]  rrd_cnt, next_rrd_cnt;
  logic [CW-1:0]  bwc_cnt, next_bwc_cnt;
  logic [CW-1:0]  act_cnt [2], next_act_cnt [2];
  logic [CW-1:0]  pre_cnt [2], next_pre_cnt [2];
  logic [CW-1:0]  bpl_cnt [2], next_bpl_cnt [2];
  logic [PW-1:0]  open_cnt [2], next_open_cnt [2];
  logic [1:0]     row_open, next_row_open;
  logic [1:0]     aref_cnt, next_aref_cnt;
  logic [3:0]     cmd, next_cmd;
  logic           cke, next_cke, dsf, next_dsf, ba, next_ba;
  logic [ROW_W-1:0] addr, next_addr;
  logic [DQM_W-1:0] dqm, next_dqm;
  logic           ready, next_ready, done, next_done, overdue, next_overdue;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == '0) ? v : v - 8'h01;
  endfunction : dec

  function automatic logic [CW-1:0] lc(input int v);
    return CW'(v > 0 ? v - 1 : 0);
  endfunction : lc

  logic b;

  always_comb begin
    next_state    = state;
    next_wait_cnt = (wait_cnt == '0) ? wait_cnt : wait_cnt - PW'(1);
    next_gap_cnt  = dec(gap_cnt);
    next_rrd_cnt  = dec(rrd_cnt);
    next_bwc_cnt  = dec(bwc_cnt);
    for (int i = 0; i < 2; i++) begin
      next_act_cnt[i]  = dec(act_cnt[i]);
      next_pre_cnt[i]  = dec(pre_cnt[i]);
      next_bpl_cnt[i]  = dec(bpl_cnt[i]);
      next_open_cnt[i] = row_open[i] ? open_cnt[i] + PW'(1) : '0;
    end
    next_row_open = row_open;
    next_aref_cnt = aref_cnt;
    next_cmd      = `SGTP_CMD_NOP;
    next_cke      = cke;
    next_dsf      = 1'b0;
    next_ba       = ba;
    next_addr     = addr;
    next_dqm      = dqm;
    next_done     = done;
    next_overdue  = overdue;
    next_ready    = 1'b0;
    b             = i_req_bank;
    for (int i = 0; i < 2; i++) begin
      if (row_open[i] && open_cnt[i] >= PW'(RAS_MAX_CYC - C_RP)) begin
        next_overdue = 1'b1;
      end
    end
    if (row_open == 2'b00) begin
      next_overdue = 1'b0;
    end
    case (state)
      sgtp_pkg::SGTP_PAUSE: begin
        next_cke = 1'b1;
        next_dqm = '1;
        if (wait_cnt == '0) begin
          next_state   = sgtp_pkg::SGTP_PREALL;
        end
      end
      sgtp_pkg::SGTP_PREALL: begin
        next_cmd                   = `SGTP_CMD_PRE;
        next_addr                  = '0;
        next_addr[`SGTP_PRE_ALL_BIT] = 1'b1;
        next_gap_cnt               = lc(C_RP);
        next_state                 = sgtp_pkg::SGTP_MRS;
      end
      sgtp_pkg::SGTP_MRS: begin
        if (gap_cnt == '0) begin
          next_cmd     = `SGTP_CMD_MRS;
          next_addr    = i_req_addr;
          next_gap_cnt = lc(C_RSC);
          next_state   = sgtp_pkg::SGTP_AREF;
        end
      end
      sgtp_pkg::SGTP_AREF: begin
        if (gap_cnt == '0) begin
          next_cmd      = `SGTP_CMD_AREF;
          next_gap_cnt  = lc(C_RC);
          next_aref_cnt = aref_cnt + 2'h1;
          if (aref_cnt == 2'(AREF_CNT - 1)) begin
            next_state = sgtp_pkg::SGTP_IDLE;
          end
        end
      end
      sgtp_pkg::SGTP_IDLE: begin
        if (gap_cnt == '0 && !done) begin
          next_done = 1'b1;
          next_dqm  = '0;
        end
        if (done && i_req_valid && ready) begin
          next_ba  = b;
          next_dqm = i_req_mask;
          case (sgtp_pkg::sgtp_req_t'(i_req_cmd))
            sgtp_pkg::SGTP_REQ_ACT: begin
              if (!row_open[b] && pre_cnt[b] == '0 && rrd_cnt == '0) begin
                next_cmd           = `SGTP_CMD_ACT;
                next_addr          = i_req_addr;
                next_row_open[b]   = 1'b1;
                next_act_cnt[b]    = lc(C_RAS > C_RCD ? C_RAS : C_RCD);
                next_rrd_cnt       = lc(C_RRD);
              end
            end
            sgtp_pkg::SGTP_REQ_READ, sgtp_pkg::SGTP_REQ_WRITE: begin
              next_cmd  = (i_req_cmd == 3'h1) ? `SGTP_CMD_READ : `SGTP_CMD_WRITE;
              next_addr = i_req_addr;
              if (i_req_cmd == 3'h2) next_bpl_cnt[b] = lc(C_WR);
            end
            sgtp_pkg::SGTP_REQ_BLKWR: begin
              if (bwc_cnt == '0) begin
                next_cmd        = `SGTP_CMD_WRITE;
                next_dsf        = 1'b1;
                next_addr       = i_req_addr;
                next_bwc_cnt    = lc(C_BWC);
                next_bpl_cnt[b] = lc(C_BPL);
              end
            end
            sgtp_pkg::SGTP_REQ_PRE: begin
              if (act_cnt[b] == '0 && bpl_cnt[b] == '0) begin
                next_cmd         = `SGTP_CMD_PRE;
                next_addr        = '0;
                next_row_open[b] = 1'b0;
                next_pre_cnt[b]  = lc(C_RP);
              end
            end
            sgtp_pkg::SGTP_REQ_AREF: begin
              if (row_open == 2'b00 && pre_cnt[0] == '0 && pre_cnt[1] == '0) begin
                next_cmd     = `SGTP_CMD_AREF;
                next_gap_cnt = lc(C_RC);
              end
            end
            sgtp_pkg::SGTP_REQ_MRS: begin
              if (row_open == 2'b00) begin
                next_cmd     = `SGTP_CMD_MRS;
                next_addr    = i_req_addr;
                next_gap_cnt = lc(C_RSC);
              end
            end
            sgtp_pkg::SGTP_REQ_PWRDN: begin
              next_cke = 1'b0;
              if (row_open == 2'b00 && i_req_addr[0]) begin
                next_cmd   = `SGTP_CMD_AREF;
                next_state = sgtp_pkg::SGTP_SELFREF;
              end else begin
                next_state = sgtp_pkg::SGTP_PWRDN;
              end
            end
            default: begin
              next_cmd = `SGTP_CMD_NOP;
            end
          endcase
        end
      end
      sgtp_pkg::SGTP_PWRDN: begin
        if (i_wake) begin
          next_cke     = 1'b1;
          next_gap_cnt = lc(C_PDE + 1);
          next_state   = sgtp_pkg::SGTP_PD_EXIT;
        end
      end
      sgtp_pkg::SGTP_SELFREF: begin
        if (i_wake) begin
          next_cke     = 1'b1;
          next_gap_cnt = lc((C_SRX > C_RC ? C_SRX : C_RC) + 1);
          next_state   = sgtp_pkg::SGTP_SR_EXIT;
        end
      end
      sgtp_pkg::SGTP_PD_EXIT, sgtp_pkg::SGTP_SR_EXIT: begin
        if (gap_cnt == '0) begin
          next_state = sgtp_pkg::SGTP_IDLE;
        end
      end
      default: begin
        next_state = sgtp_pkg::SGTP_PAUSE;
      end
    endcase
    next_ready = (next_state == sgtp_pkg::SGTP_IDLE) && next_done && (next_gap_cnt == '0) &&
                 next_cmd != `SGTP_CMD_AREF && next_cmd != `SGTP_CMD_MRS;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= sgtp_pkg::SGTP_PAUSE;
      wait_cnt <= PW'(PAUSE_CYC);
      gap_cnt  <= '0;
      rrd_cnt  <= '0;
      bwc_cnt  <= '0;
      act_cnt  <= '{default: '0};
      pre_cnt  <= '{default: '0};
      bpl_cnt  <= '{default: '0};
      open_cnt <= '{default: '0};
      row_open <= 2'h0;
      aref_cnt <= 2'h0;
      cmd      <= `SGTP_CMD_NOP;
      cke      <= 1'b1;
      dsf      <= 1'b0;
      ba       <= 1'b0;
      addr     <= '0;
      dqm      <= '1;
      ready    <= 1'b0;
      done     <= 1'b0;
      overdue  <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      gap_cnt  <= next_gap_cnt;
      rrd_cnt  <= next_rrd_cnt;
      bwc_cnt  <= next_bwc_cnt;
      act_cnt  <= next_act_cnt;
      pre_cnt  <= next_pre_cnt;
      bpl_cnt  <= next_bpl_cnt;
      open_cnt <= next_open_cnt;
      row_open <= next_row_open;
      aref_cnt <= next_aref_cnt;
      cmd      <= next_cmd;
      cke      <= next_cke;
      dsf      <= next_dsf;
      ba       <= next_ba;
      addr     <= next_addr;
      dqm      <= next_dqm;
      ready    <= next_ready;
      done     <= next_done;
      overdue  <= next_overdue;
    end
  end

  assign o_req_ready   = ready;
  assign o_init_done   = done;
  assign o_ras_overdue = overdue;
  assign o_cke         = cke;
  assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
  assign o_dsf         = dsf;
  assign o_ba          = ba;
  assign o_addr        = addr;
  assign o_dqm         = dqm;

endmodule : sgtp_ctrl

`default_nettype wire

// ==== common/sgtp_defs.svh ====
`ifndef SGTP_DEFS_SVH
`define SGTP_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define SGTP_CLK_PERIOD_PS      50000

// ----------------------------------------------------------------------------
// Timing limits in picoseconds (fastest grade shown in ns x 1000)
// ----------------------------------------------------------------------------
`define SGTP_T_RAS_MIN_PS       32000
`define SGTP_T_RAS_MAX_PS       100000000
`define SGTP_T_RP_PS            16000
`define SGTP_T_RRD_PS           11000
`define SGTP_T_RC_PS            48000
`define SGTP_T_RCD_PS           16000
`define SGTP_T_SRX_PS           5500
`define SGTP_T_PDE_PS           3500
`define SGTP_T_RSC_PS           5500
`define SGTP_T_BWC_PS           11000
`define SGTP_T_BPL_PS           11000
`define SGTP_T_WR_PS            5500
`define SGTP_T_PAUSE_PS         200000000
`define SGTP_AREF_COUNT         2

// ----------------------------------------------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------------
`define SGTP_CMD_NOP            4'hF
`define SGTP_CMD_ACT            4'h3
`define SGTP_CMD_READ           4'h5
`define SGTP_CMD_WRITE          4'h4
`define SGTP_CMD_PRE            4'h2
`define SGTP_CMD_AREF           4'h1
`define SGTP_CMD_MRS            4'h0
`define SGTP_PRE_ALL_BIT        10

`endif

// ==== common/sgtp_pkg.sv ====
package sgtp_pkg;

  typedef enum logic [8:0] {
    SGTP_PAUSE    = 9'h001,
    SGTP_PREALL   = 9'h002,
    SGTP_MRS      = 9'h004,
    SGTP_AREF     = 9'h008,
    SGTP_IDLE     = 9'h010,
    SGTP_PWRDN    = 9'h020,
    SGTP_PD_EXIT  = 9'h040,
    SGTP_SELFREF  = 9'h080,
    SGTP_SR_EXIT  = 9'h100
  } sgtp_state_t;

  typedef enum logic [2:0] {
    SGTP_REQ_ACT   = 3'h0,
    SGTP_REQ_READ  = 3'h1,
    SGTP_REQ_WRITE = 3'h2,
    SGTP_REQ_PRE   = 3'h3,
    SGTP_REQ_BLKWR = 3'h4,
    SGTP_REQ_AREF  = 3'h5,
    SGTP_REQ_MRS   = 3'h6,
    SGTP_REQ_PWRDN = 3'h7
  } sgtp_req_t;

endpackage : sgtp_pkg

// ==== verif/sgtp_ctrl_sva.sv ====
`timescale 1ns/10ps
`include "sgtp_defs.svh"
`default_nettype none

module sgtp_ctrl_sva #(
  parameter int PAUSE_CYC = 20,
  parameter int AREF_CNT  = 2,
  parameter int ROW_W     = 11,
  parameter int DQM_W     = 4
) (
  input wire logic             i_clk_sys,
  input wire logic             i_rst_n,
  input wire logic             i_req_valid,
  input wire logic [2:0]       i_req_cmd,
  input wire logic             i_req_bank,
  input wire logic [ROW_W-1:0] i_req_addr,
  input wire logic [DQM_W-1:0] i_req_mask,
  input wire logic             i_wake,
  input wire logic             o_req_ready,
  input wire logic             o_init_done,
  input wire logic             o_ras_overdue,
  input wire logic             o_cke,
  input wire logic             o_cs_n,
  input wire logic             o_ras_n,
  input wire logic             o_cas_n,
  input wire logic             o_we_n,
  input wire logic             o_dsf,
  input wire logic             o_ba,
  input wire logic [ROW_W-1:0] o_addr,
  input wire logic [DQM_W-1:0] o_dqm
);
  logic [3:0]  cmd;
  logic        is_mrs;
  logic        is_aref;
  logic [15:0] cyc;
  logic [15:0] next_cyc;
  logic [3:0]  n_aref;
  logic [3:0]  next_n_aref;
  logic        seen;
  logic        next_seen;
  logic        mrs_due;
  logic        next_mrs_due;

  assign cmd     = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  assign is_mrs  = (cmd == `SGTP_CMD_MRS);
  assign is_aref = (cmd == `SGTP_CMD_AREF);

  always_comb begin
    next_cyc    = (cyc == 16'hFFFF) ? cyc : cyc + 16'h1;
    next_seen   = seen | (cmd != `SGTP_CMD_NOP);
    // Set by the init precharge, cleared by the mode set
    next_mrs_due = (cmd == `SGTP_CMD_PRE && !o_init_done) | (mrs_due & ~is_mrs);
    next_n_aref = n_aref + {3'h0, is_aref & ~o_init_done & (n_aref != 4'hF)};
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc    <= 16'h0;
      seen   <= 1'b0;
      n_aref <= 4'h0;
      mrs_due <= 1'b0;
    end else begin
      cyc    <= next_cyc;
      seen   <= next_seen;
      mrs_due <= next_mrs_due;
      n_aref <= next_n_aref;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_mrs_soon;
    ##[1:16] is_mrs;
  endsequence
  sequence s_two_aref;
    ##[1:32] is_aref ##[1:32] is_aref;
  endsequence

  AST_RESET_PINS: assert property (
    cyc == 16'h0 |-> cmd == `SGTP_CMD_NOP && o_cke && o_dqm == '1 && !o_init_done)
    else $error("pins not idle after reset");
  AST_PAUSE_QUIET: assert property (
    cyc < PAUSE_CYC - 1 |-> cmd == `SGTP_CMD_NOP && o_dqm == '1)
    else $error("command or open byte lane in pause");
  AST_FIRST_PRE: assert property (
    !seen && cmd != `SGTP_CMD_NOP |-> cmd == `SGTP_CMD_PRE && o_addr[`SGTP_PRE_ALL_BIT])
    else $error("first command not precharge all");
  AST_MRS_SOON: assert property (
    cmd == `SGTP_CMD_PRE && !o_init_done |-> s_mrs_soon)
    else $error("no mode set after precharge");
  AST_MRS_ONLY: assert property (
    mrs_due |-> cmd == `SGTP_CMD_NOP || is_mrs)
    else $error("other command before mode set");
  AST_AREF_TWO: assert property (
    is_mrs && !o_init_done |-> s_two_aref)
    else $error("refresh pair missing after mode set");
  AST_DONE_AREF: assert property (
    $rose(o_init_done) |-> n_aref >= AREF_CNT)
    else $error("done before refreshes");
  AST_READY_BLOCKED: assert property (
    !o_init_done |-> !o_req_ready)
    else $error("ready during init");
  AST_WAKE_NOP: assert property (
    $rose(o_cke) |-> (cmd == `SGTP_CMD_NOP) [*2])
    else $error("command too soon after wake");
  AST_COL_B2B: assert property (
    i_req_valid && o_req_ready && i_req_cmd == 3'h1
    |=> cmd == `SGTP_CMD_READ && o_ba == $past(i_req_bank))
    else $error("read not issued next cycle");
endmodule : sgtp_ctrl_sva

`default_nettype wire

// ==== verif/sgtp_dev_model.sv ====
`timescale 1ns/10ps
`include "sgtp_defs.svh"
`default_nettype none

module sgtp_dev_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_cke,
  input  wire logic [3:0]  i_cmd,
  input  wire logic        i_dsf,
  input  wire logic        i_ba,
  input  wire logic [10:0] i_addr,
  input  wire logic [3:0]  i_dqm,
  output var  logic [7:0]  o_n_col,
  output var  logic [7:0]  o_n_bw,
  output var  logic [7:0]  o_n_aref,
  output var  logic [10:0] o_mode,
  output var  logic [31:0] o_lanes,
  output var  logic [1:0]  o_open,
  output var  logic        o_err
);
  initial begin
    {o_n_col, o_n_bw, o_n_aref} = 24'h0;
    {o_mode, o_lanes, o_open, o_err} = 46'h0;
  end

  // Commands with clock gate low are ignored
  always @(posedge i_clk_sys) begin
    if (i_cke) begin
      case (i_cmd)
        `SGTP_CMD_ACT: o_open[i_ba] <= 1'b1;
        `SGTP_CMD_PRE: o_open <= i_addr[10] ? 2'b00 : o_open & ~(2'b01 << i_ba);
        `SGTP_CMD_MRS: o_mode <= i_addr;
        `SGTP_CMD_AREF: begin
          o_n_aref <= o_n_aref + 8'h1;
          if (o_open != 2'b00) o_err <= 1'b1;
        end
        `SGTP_CMD_READ, `SGTP_CMD_WRITE: begin
          if (!o_open[i_ba]) o_err <= 1'b1;
          if (i_dsf) o_n_bw <= o_n_bw + 8'h1;
          else o_n_col <= o_n_col + 8'h1;
          o_lanes <= ~{{8{i_dqm[3]}}, {8{i_dqm[2]}}, {8{i_dqm[1]}}, {8{i_dqm[0]}}};
        end
        default: ;
      endcase
    end
  end
endmodule : sgtp_dev_model

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`include "sgtp_defs.svh"
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
  localparam logic [10:0] MODE = 11'h023;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_req_valid = 1'b0;
  logic [2:0]  i_req_cmd = 3'h0;
  logic        i_req_bank = 1'b0;
  logic [10:0] i_req_addr = MODE;
  logic [3:0]  i_req_mask = 4'hF;
  logic        i_wake = 1'b0;
  logic        o_req_ready, o_init_done, o_ras_overdue, o_cke, o_cs_n, o_ras_n;
  logic        o_cas_n, o_we_n, o_dsf, o_ba, err;
  logic [10:0] o_addr, mode;
  logic [3:0]  o_dqm;
  logic [7:0]  n_col, n_bw, n_aref;
  logic [31:0] lanes;
  logic [1:0]  open_b;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  sgtp_ctrl #(.PAUSE_CYC(20), .RAS_MAX_CYC(50)) sgtp_ctrl_inst (.i_clk_sys, .i_rst_n,
    .i_req_valid, .i_req_cmd, .i_req_bank, .i_req_addr, .i_req_mask, .i_wake, .o_req_ready,
    .o_init_done, .o_ras_overdue, .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_dsf, .o_ba,
    .o_addr, .o_dqm);
  sgtp_dev_model sgtp_dev_model_inst (.i_clk_sys, .i_cke(o_cke),
    .i_cmd({o_cs_n, o_ras_n, o_cas_n, o_we_n}), .i_dsf(o_dsf), .i_ba(o_ba), .i_addr(o_addr),
    .i_dqm(o_dqm), .o_n_col(n_col), .o_n_bw(n_bw), .o_n_aref(n_aref), .o_mode(mode),
    .o_lanes(lanes), .o_open(open_b), .o_err(err));

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask : tick

  // Holds the request until an edge sees ready
  task automatic req(input logic [2:0] c, input logic b, input logic [10:0] a);
    int k;
    k = 0;
    {i_req_valid, i_req_cmd, i_req_bank, i_req_addr} = {1'b1, c, b, a};
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (o_req_ready !== 1'b1 && k < 40);
    #2;
    if (k == 40) failures++;
  endtask : req

  task automatic idle();
    i_req_valid = 1'b0;
    tick(2);
  endtask : idle

  task automatic t_init();
    int k;
    logic [7:0] a0;
    k = 0;
    a0 = n_aref;
    i_req_addr = MODE;
    tick(3);
    `CHK({o_cs_n, o_cke, o_dqm}, 6'h3F)
    i_rst_n = 1'b1;
    while (o_init_done !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    `CHK(k >= 20, 1'b1)
    `CHK(n_aref - a0, 8'h2)
    `CHK(mode, MODE)
    `CHK(o_req_ready, 1'b1)
    $display("test init finished");
  endtask : t_init

  task automatic t_rows();
    logic [7:0] c0;
    c0 = n_col;
    req(3'h0, 1'b0, 11'h005);
    req(3'h0, 1'b1, 11'h006);
    req(3'h1, 1'b0, 11'h000);
    req(3'h1, 1'b1, 11'h001);
    req(3'h1, 1'b0, 11'h002);
    idle();
    `CHK(n_col - c0, 8'h3)
    `CHK(open_b, 2'b11)
    req(3'h3, 1'b0, 11'h000);
    req(3'h0, 1'b0, 11'h007);
    i_req_mask = 4'h5;
    req(3'h2, 1'b0, 11'h003);
    idle();
    `CHK(lanes, 32'hFF00FF00)
    `CHK(err, 1'b0)
    $display("test rows finished");
  endtask : t_rows

  task automatic t_bw();
    logic [7:0] b0;
    b0 = n_bw;
    req(3'h4, 1'b1, 11'h010);
    req(3'h4, 1'b1, 11'h011);
    req(3'h3, 1'b1, 11'h000);
    idle();
    `CHK(n_bw - b0, 8'h2)
    `CHK(open_b, 2'b01)
    tick(50);
    `CHK(o_ras_overdue, 1'b1)
    req(3'h3, 1'b0, 11'h000);
    idle();
    `CHK({o_ras_overdue, open_b}, 3'h0)
    $display("test block write and row limit finished");
  endtask : t_bw

  task automatic t_power();
    int k;
    for (int s = 0; s < 2; s++) begin
      req(3'h7, 1'b0, {10'h0, s[0]});
      idle();
      `CHK(o_cke, 1'b0)
      tick(4);
      i_wake = 1'b1;
      k = 0;
      while (o_cke !== 1'b1 && k < 20) begin
        tick(1);
        k++;
      end
      i_wake = 1'b0;
      req(3'h0, 1'b1, 11'h00A);
      idle();
      `CHK(open_b[1], 1'b1)
      req(3'h3, 1'b1, 11'h000);
      idle();
    end
    $display("test power-down finished");
  endtask : t_power

  task automatic t_mreset();
    req(3'h0, 1'b0, 11'h009);
    idle();
    i_rst_n = 1'b0;
    #1;
    `CHK({o_cs_n, o_cke, o_dqm, o_init_done}, 7'h7E)
    t_init();
    $display("test mid-run reset finished");
  endtask : t_mreset

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    t_init();
    i_req_mask = 4'h0;
    t_rows();
    t_bw();
    t_power();
    t_mreset();
    report_and_stop();
  end
endmodule : testbench

bind sgtp_ctrl sgtp_ctrl_sva #(.PAUSE_CYC(PAUSE_CYC), .AREF_CNT(AREF_CNT), .ROW_W(ROW_W),
  .DQM_W(DQM_W)) sgtp_ctrl_sva_inst (.i_clk_sys, .i_rst_n, .i_req_valid, .i_req_cmd,
  .i_req_bank, .i_req_addr, .i_req_mask, .i_wake, .o_req_ready, .o_init_done, .o_ras_overdue,
  .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_dsf, .o_ba, .o_addr, .o_dqm);

`default_nettype wire
